// [hw/dac_control_interface.sv]
/*
  Control logic of one 8-bit converter: AXI4-Lite register slave, enable and
  conversion start, pin buffer gating, sleep handling and start-up delay.
  Assumes sleep and debug levels come from logic on the same clock.
*/
// The implementer's own choice: the AXI4-Lite slave port.
// How it works
// - Writing one to the enable bit switches the converter on and writing zero switches it off.
// - While enabled and past the start-up delay, every value register write starts a new conversion at once.
// - While disabled, a value write is only stored; conversion starts after the start-up delay once enable is written one.
// - While the converter is enabled, setting the pin buffer enable bit turns on the output buffer and drives the pin.
// - With run_in_standby set the converter and buffer keep running in standby sleep.
// - With run_in_standby clear, standby sleep stops conversion and turns converter and buffer off.
// - On leaving standby the converter and configured buffer come back at once; output and conversion follow after a start-up delay.
// - Power-down sleep always turns converter and buffer off.
// - When enabled and past start-up the output is offered internally to comparator and ADC, pin buffer or not.
// - Only instance zero has a pin driver; the others are internal only.
// - Debug halt does not change behaviour.
// - The value register is 8 bits read/write and resets to zero.
`timescale 1ns/10ps
module dac_control_interface
  import dac_ctl_pkg::*;
#(
  parameter bit HAS_PIN_DRIVER = 1'b1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        standby_sleep,
  input  wire logic        powerdown_sleep,
  input  wire logic        debug_halt,
  output logic [7:0]       core_code,
  output logic             core_enable,
  output logic             core_convert,
  output logic             pin_buffer_on,
  output logic             internal_out_valid
);
  typedef enum logic [2:0] {
    ST_OFF   = 3'b001,
    ST_START = 3'b010,
    ST_RUN   = 3'b100
  } core_state_t;

  localparam int CNT_W = $clog2(STARTUP_CYCLES + 1);

  logic [7:0]       ctrl_ff;
  logic [7:0]       value_ff;
  logic [11:0]      awaddr_ff;
  logic             aw_held_ff;
  logic [31:0]      wdata_ff;
  logic [3:0]       wstrb_ff;
  logic             w_held_ff;
  logic             pend_conv_ff;
  logic [CNT_W-1:0] start_cnt_ff;
  core_state_t      state_ff;
  core_state_t      nxt_state;
  logic             do_write;
  logic             ctrl_wr;
  logic             value_wr;
  logic [7:0]       nxt_ctrl;
  logic             gate_off;
  logic             enable_rise;

  // Debug halt is deliberately unused by the core path
  wire unused_debug = debug_halt;

  assign do_write    = aw_held_ff && w_held_ff && !s_axi_bvalid;
  assign ctrl_wr     = do_write && awaddr_ff == CTRL_ADDR && wstrb_ff[0];
  assign value_wr    = do_write && awaddr_ff == VALUE_ADDR && wstrb_ff[0];
  assign nxt_ctrl    = wdata_ff[7:0] & CTRL_WMASK;
  assign enable_rise = ctrl_wr && nxt_ctrl[ENABLE_BIT] && !ctrl_ff[ENABLE_BIT];
  assign gate_off    = powerdown_sleep || (standby_sleep && !ctrl_ff[RUN_STBY_BIT]);

  // Address and data accepted in either order, held until the response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff    <= 1'b0;
      w_held_ff     <= 1'b0;
      awaddr_ff     <= 12'h000;
      wdata_ff      <= 32'h0000_0000;
      wstrb_ff      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_ff && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
      s_axi_wready  <= !w_held_ff && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_ff == CTRL_ADDR || awaddr_ff == VALUE_ADDR ||
                         awaddr_ff == STATUS_ADDR) ? RESP_OKAY : RESP_SLVERR;
        aw_held_ff   <= 1'b0;
        w_held_ff    <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Value register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      value_ff <= VALUE_RESET;
    end else if (value_wr) begin
      value_ff <= wdata_ff[7:0];
    end
  end

  // Conversion requests; a stored value waits for enable or wake-up
  // A write that converts at once must not also leave a request, or it would convert twice
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_conv_ff <= 1'b0;
    end else if (enable_rise || state_ff == ST_START ||
                 (value_wr && ctrl_ff[ENABLE_BIT] &&
                  !(state_ff == ST_RUN && nxt_state == ST_RUN))) begin
      pend_conv_ff <= 1'b1;
    end else if ((state_ff == ST_RUN && nxt_state == ST_RUN) || !ctrl_ff[ENABLE_BIT]) begin
      pend_conv_ff <= 1'b0;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_OFF: begin
        if (ctrl_ff[ENABLE_BIT] && !gate_off) begin
          nxt_state = ST_START;
        end
      end
      ST_START: begin
        if (!ctrl_ff[ENABLE_BIT] || gate_off) begin
          nxt_state = ST_OFF;
        end else if (start_cnt_ff == CNT_W'(STARTUP_CYCLES - 1)) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!ctrl_ff[ENABLE_BIT] || gate_off) begin
          nxt_state = ST_OFF;
        end
      end
      default: nxt_state = ST_OFF;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Start-up wait before the first conversion after enable or wake-up
  always_ff @(posedge aclk) begin
    if (!aresetn || state_ff != ST_START) begin
      start_cnt_ff <= '0;
    end else begin
      start_cnt_ff <= start_cnt_ff + CNT_W'(1);
    end
  end

  // Analog core drive
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_code          <= 8'h00;
      core_enable        <= 1'b0;
      core_convert       <= 1'b0;
      pin_buffer_on      <= 1'b0;
      internal_out_valid <= 1'b0;
    end else begin
      core_enable        <= nxt_state != ST_OFF;
      internal_out_valid <= nxt_state == ST_RUN;
      pin_buffer_on      <= HAS_PIN_DRIVER && nxt_state != ST_OFF &&
                            ctrl_ff[PIN_BUF_BIT];
      core_convert       <= 1'b0;
      if (state_ff == ST_RUN && nxt_state == ST_RUN && value_wr) begin
        core_code    <= wdata_ff[7:0];
        core_convert <= 1'b1;
      end else if (state_ff == ST_RUN && nxt_state == ST_RUN && pend_conv_ff) begin
        core_code    <= value_ff;
        core_convert <= 1'b1;
      end
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        unique case ({s_axi_araddr[11:2], 2'b00})
          CTRL_ADDR:   s_axi_rdata <= {24'h000000, ctrl_ff};
          VALUE_ADDR:  s_axi_rdata <= {24'h000000, value_ff};
          STATUS_ADDR: s_axi_rdata <= {28'h0000000, gate_off, state_ff == ST_START,
                                       pin_buffer_on, core_enable};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  property p_value_conv;
    @(posedge aclk) disable iff (!aresetn)
      (value_wr && state_ff == ST_RUN && nxt_state == ST_RUN) |=> core_convert && core_code == $past(wdata_ff[7:0]);
  endproperty
  a_value_conv: assert property (p_value_conv) else $error("value write did not convert");

  property p_single_conv;
    @(posedge aclk) disable iff (!aresetn)
      (value_wr && state_ff == ST_RUN && nxt_state == ST_RUN) |=> ##1 !core_convert;
  endproperty
  a_single_conv: assert property (p_single_conv) else $error("write converted twice");

  property p_off_no_conv;
    @(posedge aclk) disable iff (!aresetn) !ctrl_ff[ENABLE_BIT] |=> !core_convert;
  endproperty
  a_off_no_conv: assert property (p_off_no_conv) else $error("converted while disabled");

  property p_enable_on;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_ff[ENABLE_BIT] && !gate_off)[*2] |-> core_enable;
  endproperty
  a_enable_on: assert property (p_enable_on) else $error("core not on");

  property p_pd_off;
    @(posedge aclk) disable iff (!aresetn) powerdown_sleep |=> !core_enable && !pin_buffer_on;
  endproperty
  a_pd_off: assert property (p_pd_off) else $error("on in power-down");

  property p_stby_off;
    @(posedge aclk) disable iff (!aresetn)
      (standby_sleep && !ctrl_ff[RUN_STBY_BIT]) |=> !core_enable;
  endproperty
  a_stby_off: assert property (p_stby_off) else $error("on in standby");

  property p_stby_run;
    @(posedge aclk) disable iff (!aresetn)
      (state_ff == ST_RUN && ctrl_ff[ENABLE_BIT] && ctrl_ff[RUN_STBY_BIT] && standby_sleep &&
       !powerdown_sleep) |=> core_enable;
  endproperty
  a_stby_run: assert property (p_stby_run) else $error("stopped in standby");

  property p_startup;
    @(posedge aclk) disable iff (!aresetn)
      $rose(state_ff == ST_START) |-> !internal_out_valid[*2];
  endproperty
  a_startup: assert property (p_startup) else $error("no start-up delay");

  property p_pin;
    @(posedge aclk) disable iff (!aresetn)
      pin_buffer_on |-> HAS_PIN_DRIVER && core_enable && $past(ctrl_ff[PIN_BUF_BIT]);
  endproperty
  a_pin: assert property (p_pin) else $error("pin buffer wrong");

  property p_internal;
    @(posedge aclk) disable iff (!aresetn) internal_out_valid |-> core_enable;
  endproperty
  a_internal: assert property (p_internal) else $error("internal without enable");

  c_conv:   cover property (@(posedge aclk) disable iff (!aresetn) core_convert);
  c_wake:   cover property (@(posedge aclk) disable iff (!aresetn) $fell(standby_sleep) ##[1:200] core_convert);
  c_pinbuf: cover property (@(posedge aclk) disable iff (!aresetn) pin_buffer_on && internal_out_valid);
endmodule : dac_control_interface

// [hw/dac_ctl_pkg.sv]
/*
  Constants for the 8-bit converter control block: register map, field
  positions, reset values and start-up timing.
  Assumes a 100 MHz clock and AXI4-Lite register access.
*/
package dac_ctl_pkg;
  localparam int          REG_IDX_W          = 1;
  localparam int          CTRL_INDEX         = 0;
  localparam int          VALUE_INDEX        = 1;
  localparam logic [11:0] CTRL_ADDR          = 12'h000;
  localparam logic [11:0] VALUE_ADDR         = 12'h004;
  localparam logic [11:0] STATUS_ADDR        = 12'h008;
  localparam int          ENABLE_BIT         = 0;
  localparam int          PIN_BUF_BIT        = 6;
  localparam int          RUN_STBY_BIT       = 7;
  localparam logic [7:0]  CTRL_RESET         = 8'h00;
  localparam logic [7:0]  VALUE_RESET        = 8'h00;
  localparam logic [7:0]  CTRL_WMASK         = 8'hC1;
  localparam int          STAT_ACTIVE_BIT    = 0;
  localparam int          STAT_PIN_BIT       = 1;
  localparam int          STAT_STARTUP_BIT   = 2;
  localparam int          STAT_SLEEP_BIT     = 3;
  localparam int          CLK_PERIOD_NS      = 10;
  localparam int          STARTUP_TIME_NS    = 1000;
  localparam int          STARTUP_CYCLES     = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0]  RESP_OKAY          = 2'h0;
  localparam logic [1:0]  RESP_SLVERR        = 2'h2;
endpackage : dac_ctl_pkg

// [dv/tb.sv]
/*
  Self-checking bench for the converter control block: register access,
  conversion start, pin buffer, sleep gating and start-up delay.
  Assumes the package constants, a 100 MHz clock and an AXI4-Lite master here.
*/
`timescale 1ns/10ps
module tb;
  import dac_ctl_pkg::*;
  logic        aclk, aresetn, standby_sleep, powerdown_sleep, debug_halt;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, pin1, en1;
  logic        core_enable, core_convert, pin_buffer_on, internal_out_valid;
  logic [7:0]  core_code, conv_code;
  int          fails, tests_run, conv_n, cycles, n, c0;

  dac_control_interface i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .standby_sleep, .powerdown_sleep, .debug_halt,
    .core_code, .core_enable, .core_convert, .pin_buffer_on, .internal_out_valid);

  // Second instance without pin driver shares every input
  dac_control_interface #(.HAS_PIN_DRIVER(1'b0)) i_dut1 (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready, .standby_sleep, .powerdown_sleep,
    .debug_halt, .core_code(), .core_enable(en1), .core_convert(), .pin_buffer_on(pin1),
    .internal_out_valid());

  initial aclk = 1'b0;
  always #5 aclk = ~aclk;

  // Counts conversion pulses and keeps the code that went with the last one
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (core_convert === 1'b1) begin
      conv_n    <= conv_n + 1;
      conv_code <= core_code;
    end
    if (cycles == 5000) begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check

  // Ready is sampled mid-cycle; it is registered, so it equals the edge value
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    hb = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!hb) begin
      @(negedge aclk);
      ha  = s_axi_awvalid & s_axi_awready;
      hw  = s_axi_wvalid & s_axi_wready;
      hb  = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb) s_axi_bready <= 1'b0;
    end
  endtask : axi_write

  task automatic axi_read(input logic [11:0] a);
    logic ha, hr;
    hr = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!hr) begin
      @(negedge aclk);
      ha  = s_axi_arvalid & s_axi_arready;
      hr  = s_axi_rvalid;
      rd  = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr) s_axi_rready <= 1'b0;
    end
  endtask : axi_read

  task automatic wait_start();
    @(negedge aclk);
    n = 0;
    while (internal_out_valid !== 1'b1 && n < 400) begin
      @(negedge aclk);
      n++;
    end
  endtask : wait_start

  task automatic t_reset_values();
    axi_read(CTRL_ADDR);
    check(rd, {24'h0, CTRL_RESET}, "ctrl reset");
    axi_read(VALUE_ADDR);
    check(rd, {24'h0, VALUE_RESET}, "value reset");
    axi_read(12'h010);
    check(rsp, RESP_SLVERR, "unmapped read");
    check(core_enable, 1'b0, "enable after reset");
  endtask : t_reset_values

  task automatic t_store_then_enable();
    axi_write(VALUE_ADDR, 32'h0000_005A);
    repeat (3) @(negedge aclk);
    check(conv_n, 0, "no convert while off");
    axi_read(VALUE_ADDR);
    check(rd, 32'h0000_005A, "value readback");
    axi_write(CTRL_ADDR, 32'h0000_0041);
    @(negedge aclk);
    check(core_enable, 1'b1, "enable on");
    check(pin_buffer_on, 1'b1, "pin buffer on");
    check(pin1, 1'b0, "no pin on other instance");
    check(en1, 1'b1, "other instance enabled");
    wait_start();
    check(n >= STARTUP_CYCLES - 5 && n <= STARTUP_CYCLES, 1'b1, "start-up length");
    repeat (2) @(negedge aclk);
    check(conv_n, 1, "stored value converts");
    check(conv_code, 8'h5A, "stored code");
  endtask : t_store_then_enable

  task automatic t_enabled_writes();
    logic [7:0] vals [3];
    vals = '{8'hA5, 8'h00, 8'hFF};
    foreach (vals[i]) begin
      c0 = conv_n;
      axi_write(VALUE_ADDR, {24'h0, vals[i]});
      @(negedge aclk);
      check(conv_n, c0 + 1, "convert per write");
      check(conv_code, vals[i], "converted code");
    end
    c0 = conv_n;
    @(posedge aclk);
    s_axi_wstrb <= 4'hE;
    axi_write(VALUE_ADDR, 32'h0000_0011);
    s_axi_wstrb <= 4'hF;
    repeat (2) @(negedge aclk);
    check(conv_n, c0, "strobe-less write ignored");
    axi_read(VALUE_ADDR);
    check(rd, 32'h0000_00FF, "value kept");
  endtask : t_enabled_writes

  task automatic t_sleep();
    axi_write(CTRL_ADDR, 32'h0000_0001);
    wait_start();
    check(pin_buffer_on, 1'b0, "pin buffer off");
    check(internal_out_valid, 1'b1, "internal use without pin");
    axi_write(CTRL_ADDR, 32'h0000_0041);
    wait_start();
    @(posedge aclk);
    standby_sleep <= 1'b1;
    repeat (2) @(negedge aclk);
    check({core_enable, pin_buffer_on, internal_out_valid}, 3'b000, "standby off");
    axi_read(STATUS_ADDR);
    check(rd, 32'h1 << STAT_SLEEP_BIT, "status in standby");
    c0 = conv_n;
    @(posedge aclk);
    standby_sleep <= 1'b0;
    repeat (2) @(negedge aclk);
    check({core_enable, pin_buffer_on}, 2'b11, "wake on");
    wait_start();
    check(n >= STARTUP_CYCLES - 5 && n <= STARTUP_CYCLES, 1'b1, "wake start-up");
    repeat (2) @(negedge aclk);
    check(conv_n, c0 + 1, "wake convert");
    check(conv_code, 8'hFF, "wake code");
    axi_write(CTRL_ADDR, 32'h0000_00C1);
    wait_start();
    @(posedge aclk);
    standby_sleep <= 1'b1;
    debug_halt    <= 1'b1;
    repeat (3) @(negedge aclk);
    check({core_enable, pin_buffer_on, internal_out_valid}, 3'b111, "run in standby");
    @(posedge aclk);
    powerdown_sleep <= 1'b1;
    repeat (2) @(negedge aclk);
    check({core_enable, pin_buffer_on}, 2'b00, "power-down off");
    @(posedge aclk);
    powerdown_sleep <= 1'b0;
    standby_sleep   <= 1'b0;
    debug_halt      <= 1'b0;
    wait_start();
    axi_write(CTRL_ADDR, 32'h0000_0000);
    @(negedge aclk);
    check({core_enable, internal_out_valid}, 2'b00, "disable");
    axi_write(CTRL_ADDR, 32'h0000_00FF);
    axi_read(CTRL_ADDR);
    check(rd, {24'h0, CTRL_WMASK}, "ctrl unused bits");
  endtask : t_sleep

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    {aresetn, standby_sleep, powerdown_sleep, debug_halt} = 4'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    fails     = 0;
    tests_run = 0;
    conv_n    = 0;
    cycles    = 0;
    conv_code = 8'h00;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_values();
    t_store_then_enable();
    t_enabled_writes();
    t_sleep();
    tally_and_finish();
  end
endmodule : tb
